// ==== design/reset_source_controller_params.svh ====
// Constants for the reset source controller: offsets, field positions, resets, timings.
// Assumes a 40 MHz always-on clock and a 32-bit APB register bus.
`ifndef RESET_SOURCE_CONTROLLER_PARAMS_SVH
`define RESET_SOURCE_CONTROLLER_PARAMS_SVH

// ==========================================================
// Register byte offsets
`define RSC_OFF_CAUSE0 12'h000
`define RSC_OFF_CAUSE1 12'h004
`define RSC_OFF_CAUSE2 12'h008
`define RSC_OFF_PVDCTL 12'h00c
`define RSC_OFF_WDSTAT 12'h010
`define RSC_OFF_WAKE 12'h014
`define RSC_OFF_SWREQ 12'h018

// ==========================================================
// Field positions
`define RSC_C0_POR 0
`define RSC_C0_PVD0 1
`define RSC_C0_PVD1 2
`define RSC_C0_PVD2 3
`define RSC_C0_DPS 4
`define RSC_C0_BATT 5
`define RSC_C1_INDEPENDENT_WATCHDOG 0
`define RSC_C1_WDT 1
`define RSC_C1_SW 2
`define RSC_C1_LOCK 3
`define RSC_C1_BUS 4
`define RSC_C1_MEM 5
`define RSC_C2_CWS 0
`define RSC_SWREQ_BIT 2

// ==========================================================
// Reset values and timing
`define RSC_PVDCTL_RST 8'h00
`define RSC_CLK_HZ 40000000
`define RSC_POR_HOLD_US 1000
`define RSC_PVD_STAB_US 300
`define RSC_DSBY_WAIT_US 200
`define RSC_SW_DELAY_NS 500
`define RSC_CYC_US(us) (((us) * 40 + 0) )
`define RSC_SW_DELAY_CYC ((`RSC_SW_DELAY_NS + 24) / 25)

`endif

// ==== design/reset_source_pkg.sv ====
// Types shared by the reset source controller files.
// Assumes the parameter header is included by the users of the constants.
package reset_source_pkg;
  typedef enum logic [2:0] {
    ST_POR = 3'b000,
    ST_HOLD = 3'b001,
    ST_WAIT = 3'b010,
    ST_RUN = 3'b011
  } seq_state_e;
  typedef logic [31:0] hold_cnt_t;
endpackage

// ==== design/level_sync3.sv ====
// Three-stage synchroniser for asynchronous level inputs with agreement filter.
// Assumes pclk domain; output changes once stages two and three agree.
module level_sync3 #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] INIT = '0
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [WIDTH-1:0] din,
  output logic [WIDTH-1:0] dout
);
  typedef struct packed {
    logic [WIDTH-1:0] s1;
    logic [WIDTH-1:0] s2;
    logic [WIDTH-1:0] s3;
    logic [WIDTH-1:0] q;
  } sync_s;
  sync_s st_ff;
  sync_s nxt_st;

  always_comb
  begin
    nxt_st = st_ff;
    nxt_st.s1 = din;
    nxt_st.s2 = st_ff.s1;
    nxt_st.s3 = st_ff.s2;
    for (int i = 0; i < WIDTH; i++)
    begin
      if (st_ff.s2[i] == st_ff.s3[i])
      begin
        nxt_st.q[i] = st_ff.s3[i];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      st_ff <= {INIT, INIT, INIT, INIT};
    end
    else
    begin
      st_ff <= nxt_st;
    end
  end

  assign dout = st_ff.q;
endmodule

// ==== design/hold_timer.sv ====
// Down-counter that measures a release wait after its start pulse.
// Assumes start and load come from logic on the same clock.
module hold_timer (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic start,
  input wire logic [31:0] load,
  output logic done
);
  typedef struct packed {
    logic [31:0] cnt;
    logic busy;
  } tmr_s;
  tmr_s st_ff;
  tmr_s nxt_st;

  always_comb
  begin
    nxt_st = st_ff;
    if (start)
    begin
      nxt_st.cnt = load;
      nxt_st.busy = 1'b1;
    end
    else if (st_ff.busy)
    begin
      if (st_ff.cnt <= 32'h0000_0001)
      begin
        nxt_st.busy = 1'b0;
      end
      else
      begin
        nxt_st.cnt = st_ff.cnt - 32'h0000_0001;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      st_ff <= '0;
    end
    else
    begin
      st_ff <= nxt_st;
    end
  end

  assign done = !st_ff.busy && !start;
endmodule

// ==== design/reset_source_controller.sv ====
// Reset source controller: merges reset sources, times their release, keeps cause flags.
// Assumes presetn is the power-on-detect reset, pclk is the always-on 40 MHz clock.
// Contract
// - Low reset pin aborts everything and holds reset while low.
// - Supply below power-on threshold with pin high raises power-on reset.
// - Power-on reset leaves only after supply is good and hold time elapses.
// - Power-on sets power-on cause flag; pin reset clears it.
// - Monitor 0 has 8 levels; monitors 1 and 2 have 13 each.
// - Enabled monitor below level gives interrupt or reset, as configured.
// - Monitor reset releases after supply recovers and stabilisation wait; once dps_flag has been set, the code uses the deep standby wait instead.
// - Option word bit enables monitor 0 detection after reset.
// - Monitors 1 and 2 off after power-on; enabled only via comparator control.
// - Monitor n reset sets that monitor's reset cause flag.
// - Independent watchdog underflow sets its flag and gives reset or NMI.
// - Independent watchdog reset lasts exactly one count cycle.
// - System watchdog expiry sets flag, reset or NMI, reset one count cycle.
// - Deep standby cancel raises reset, starts oscillation, releases after wait.
// - Deep standby reset sets the wake flag of the cancelling interrupt.
// - Writing 1 to the system reset request bit makes a software reset.
// - Software reset sets its flag and releases after a short fixed delay.
// - Only power-on reset clears the cold/warm start flag.
// - Writing 1 sets the cold/warm start flag; writing 0 leaves it.
// - Lockup, bus errors and memory errors raise a reset.
// - Battery supply below its threshold raises battery power-on reset.
`include "reset_source_controller_params.svh"
module reset_source_controller #(
  parameter int POR_HOLD_CYC = `RSC_CYC_US(`RSC_POR_HOLD_US),
  parameter int PVD_STAB_CYC = `RSC_CYC_US(`RSC_PVD_STAB_US),
  parameter int DSBY_WAIT_CYC = `RSC_CYC_US(`RSC_DSBY_WAIT_US),
  parameter int WAKE_W = 8
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic external_reset_pin_n,
  input wire logic supply_above_por,
  input wire logic [2:0] monitor_below,
  input wire logic battery_below_por,
  input wire logic monitor0_after_reset_select,
  input wire logic independent_watchdog_underflow,
  input wire logic independent_watchdog_count_tick,
  input wire logic independent_watchdog_reset_select,
  input wire logic wdt_underflow,
  input wire logic wdt_count_tick,
  input wire logic wdt_reset_select,
  input wire logic cpu_lockup,
  input wire logic bus_error,
  input wire logic mem_error,
  input wire logic deep_standby_cancel,
  input wire logic [WAKE_W-1:0] deep_standby_wake_src,
  output logic system_reset,
  output logic oscillator_start,
  output logic [2:0] monitor_level_irq,
  output logic watchdog_nmi,
  output logic [2:0] monitor0_level_sel,
  output logic [3:0] monitor1_level_sel,
  output logic [3:0] monitor2_level_sel
);
  localparam logic [3:0] MON12_MAX = 4'hc;

  // ==========================================================
  // Input synchronisers
  logic [2:0] pin_s;
  logic [4:0] ana_s;
  // The pin idles high, so a fresh synchroniser must not report a pin reset.
  level_sync3 #(.WIDTH(3), .INIT(3'b100)) u_sync_pin (
    .pclk(pclk),
    .presetn(presetn),
    .din({external_reset_pin_n, supply_above_por, battery_below_por}),
    .dout(pin_s)
  );
  level_sync3 #(.WIDTH(5), .INIT(5'h00)) u_sync_ana (
    .pclk(pclk),
    .presetn(presetn),
    .din({monitor_below, monitor0_after_reset_select, 1'b0}),
    .dout(ana_s)
  );
  wire logic pin_ok = pin_s[2];
  wire logic vcc_ok = pin_s[1];
  wire logic batt_low = pin_s[0];
  wire logic [2:0] mon_low = ana_s[4:2];
  wire logic mon0_opt = ana_s[1];

  // ==========================================================
  // State
  typedef struct packed {
    reset_source_pkg::seq_state_e seq;
    logic por_flag;
    logic [2:0] pvd_flag;
    logic dps_flag;
    logic batt_flag;
    logic independent_watchdog_flag;
    logic wdt_flag;
    logic sw_flag;
    logic lock_flag;
    logic bus_flag;
    logic mem_flag;
    logic cws_flag;
    logic [2:0] mon_en;
    logic [2:0] mon_rst_sel;
    logic [2:0] lvl0;
    logic [3:0] lvl1;
    logic [3:0] lvl2;
    logic [WAKE_W-1:0] wake;
    logic wd_pulse;
    logic pin_seen_low;
    logic sw_req;
    logic [31:0] rdata;
    logic rst;
  } ctl_s;
  ctl_s st_ff;
  ctl_s nxt_st;

  function automatic logic is_addr(input logic [11:0] a, input logic [11:0] off);
    is_addr = (a == off);
  endfunction

  wire logic acc = psel && penable;
  wire logic wr = acc && pwrite;
  wire logic [2:0] mon_trip = mon_low & st_ff.mon_en;
  wire logic [2:0] mon_rst = mon_trip & st_ff.mon_rst_sel;
  wire logic independent_watchdog_rst = independent_watchdog_underflow && independent_watchdog_reset_select;
  wire logic wdt_rst = wdt_underflow && wdt_reset_select;
  wire logic err_rst = cpu_lockup || bus_error || mem_error;
  logic tmr_start;
  logic [WAKE_W-1:0] wake_set;
  logic [31:0] tmr_load;
  logic tmr_done;

  hold_timer u_timer (
    .pclk(pclk),
    .presetn(presetn),
    .start(tmr_start),
    .load(tmr_load),
    .done(tmr_done)
  );

  // ==========================================================
  // Sequencer and cause flags
  always_comb
  begin
    nxt_st = st_ff;
    tmr_start = 1'b0;
    tmr_load = POR_HOLD_CYC;
    nxt_st.wd_pulse = 1'b0;
    nxt_st.sw_req = 1'b0;
    wake_set = '0;
    // The strap settles with the supply sync, so the last power-on cycle sees it.
    if (st_ff.seq == reset_source_pkg::ST_POR)
    begin
      nxt_st.mon_en[0] = mon0_opt;
      nxt_st.mon_rst_sel[0] = 1'b1;
    end
    if (!vcc_ok && pin_ok)
    begin
      nxt_st.seq = reset_source_pkg::ST_POR;
      nxt_st.por_flag = 1'b1;
      nxt_st.cws_flag = 1'b0;
      nxt_st.mon_en[2:1] = 2'b00;
    end
    else if (!pin_ok)
    begin
      nxt_st.seq = reset_source_pkg::ST_HOLD;
      nxt_st.pin_seen_low = 1'b1;
    end
    else
    begin
      unique case (st_ff.seq)
        reset_source_pkg::ST_POR:
        begin
          tmr_start = 1'b1;
          tmr_load = POR_HOLD_CYC;
          nxt_st.seq = reset_source_pkg::ST_WAIT;
        end
        reset_source_pkg::ST_HOLD:
        begin
          if (st_ff.pin_seen_low)
          begin
            nxt_st.por_flag = 1'b0;
            nxt_st.pin_seen_low = 1'b0;
          end
          if (mon_rst == 3'b000)
          begin
            tmr_start = 1'b1;
            tmr_load = st_ff.dps_flag ? 32'(DSBY_WAIT_CYC) : 32'(PVD_STAB_CYC);
            nxt_st.seq = reset_source_pkg::ST_WAIT;
          end
        end
        reset_source_pkg::ST_WAIT:
        begin
          if (mon_rst != 3'b000)
          begin
            nxt_st.seq = reset_source_pkg::ST_HOLD;
          end
          else if (tmr_done)
          begin
            nxt_st.seq = reset_source_pkg::ST_RUN;
          end
        end
        reset_source_pkg::ST_RUN:
        begin
          if (mon_rst != 3'b000 || batt_low || deep_standby_cancel || err_rst)
          begin
            nxt_st.seq = reset_source_pkg::ST_HOLD;
          end
          if (deep_standby_cancel)
          begin
            nxt_st.dps_flag = 1'b1;
            wake_set = deep_standby_wake_src;
          end
          if (st_ff.sw_req)
          begin
            nxt_st.sw_flag = 1'b1;
            tmr_start = 1'b1;
            tmr_load = `RSC_SW_DELAY_CYC;
            nxt_st.seq = reset_source_pkg::ST_WAIT;
          end
          if ((independent_watchdog_rst && independent_watchdog_count_tick) || (wdt_rst && wdt_count_tick))
          begin
            nxt_st.wd_pulse = 1'b1;
          end
        end
        default:
        begin
          nxt_st.seq = reset_source_pkg::ST_HOLD;
        end
      endcase
    end
    // Event flags: a set always beats a software clear in the same cycle.
    nxt_st.pvd_flag = st_ff.pvd_flag | mon_rst;
    nxt_st.batt_flag = st_ff.batt_flag | batt_low;
    nxt_st.lock_flag = st_ff.lock_flag | cpu_lockup;
    nxt_st.bus_flag = st_ff.bus_flag | bus_error;
    nxt_st.mem_flag = st_ff.mem_flag | mem_error;
    if (wr && is_addr(paddr, `RSC_OFF_WDSTAT))
    begin
      nxt_st.independent_watchdog_flag = st_ff.independent_watchdog_flag & pwdata[`RSC_C1_INDEPENDENT_WATCHDOG];
      nxt_st.wdt_flag = st_ff.wdt_flag & pwdata[`RSC_C1_WDT];
    end
    if (independent_watchdog_underflow)
    begin
      nxt_st.independent_watchdog_flag = 1'b1;
    end
    if (wdt_underflow)
    begin
      nxt_st.wdt_flag = 1'b1;
    end
    if (wr && is_addr(paddr, `RSC_OFF_CAUSE2) && pwdata[`RSC_C2_CWS])
    begin
      nxt_st.cws_flag = 1'b1;
    end
    if (wr && is_addr(paddr, `RSC_OFF_PVDCTL))
    begin
      nxt_st.mon_en[2:1] = pwdata[2:1];
      nxt_st.mon_rst_sel = pwdata[6:4];
      nxt_st.lvl0 = pwdata[10:8];
      if (pwdata[15:12] <= MON12_MAX)
      begin
        nxt_st.lvl1 = pwdata[15:12];
      end
      if (pwdata[19:16] <= MON12_MAX)
      begin
        nxt_st.lvl2 = pwdata[19:16];
      end
    end
    if (wr && is_addr(paddr, `RSC_OFF_SWREQ) && pwdata[`RSC_SWREQ_BIT])
    begin
      nxt_st.sw_req = 1'b1;
    end
    if (wr && is_addr(paddr, `RSC_OFF_WAKE))
    begin
      nxt_st.wake = st_ff.wake & ~pwdata[WAKE_W-1:0];
    end
    nxt_st.wake = nxt_st.wake | wake_set;
    nxt_st.rdata = 32'h0000_0000;
    if (psel && !penable && !pwrite)
    begin
      unique case (paddr)
        `RSC_OFF_CAUSE0:
          nxt_st.rdata = {26'h0, st_ff.batt_flag, st_ff.dps_flag, st_ff.pvd_flag, st_ff.por_flag};
        `RSC_OFF_CAUSE1:
          nxt_st.rdata = {26'h0, st_ff.mem_flag, st_ff.bus_flag, st_ff.lock_flag,
            st_ff.sw_flag, st_ff.wdt_flag, st_ff.independent_watchdog_flag};
        `RSC_OFF_CAUSE2:
          nxt_st.rdata = {31'h0, st_ff.cws_flag};
        `RSC_OFF_PVDCTL:
          nxt_st.rdata = {12'h0, st_ff.lvl2, st_ff.lvl1, 1'b0, st_ff.lvl0, 1'b0,
            st_ff.mon_rst_sel, 1'b0, st_ff.mon_en};
        `RSC_OFF_WDSTAT:
          nxt_st.rdata = {30'h0, st_ff.wdt_flag, st_ff.independent_watchdog_flag};
        `RSC_OFF_WAKE:
          nxt_st.rdata = {{(32 - WAKE_W){1'b0}}, st_ff.wake};
        default:
          nxt_st.rdata = 32'h0000_0000;
      endcase
    end
    nxt_st.rst = (nxt_st.seq != reset_source_pkg::ST_RUN) || nxt_st.wd_pulse;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      st_ff <= '0;
      st_ff.por_flag <= 1'b1;
      st_ff.rst <= 1'b1;
    end
    else
    begin
      st_ff <= nxt_st;
    end
  end

  // ==========================================================
  // Outputs
  assign system_reset = st_ff.rst;
  assign oscillator_start = st_ff.dps_flag && (st_ff.seq != reset_source_pkg::ST_RUN);
  assign monitor_level_irq = mon_trip & ~st_ff.mon_rst_sel;
  assign watchdog_nmi = (independent_watchdog_underflow && !independent_watchdog_reset_select)
    || (wdt_underflow && !wdt_reset_select);
  assign monitor0_level_sel = st_ff.lvl0;
  assign monitor1_level_sel = st_ff.lvl1;
  assign monitor2_level_sel = st_ff.lvl2;
  assign prdata = st_ff.rdata;
  // Slave answers in the access phase after read data was registered in setup.
  assign pready = acc;
  assign pslverr = 1'b0;

  // ==========================================================
  // Checks
  chk_pin_holds: assert property (@(posedge pclk) disable iff (!presetn)
    !pin_ok |=> system_reset) else $error("reset not held with pin low");
  chk_por_flag: assert property (@(posedge pclk) disable iff (!presetn)
    (!vcc_ok && pin_ok) |=> st_ff.por_flag) else $error("power-on flag not set");
  chk_cws_hold: assert property (@(posedge pclk) disable iff (!presetn)
    (st_ff.cws_flag && vcc_ok) |=> st_ff.cws_flag) else $error("warm flag lost");
  chk_cws_set: assert property (@(posedge pclk) disable iff (!presetn)
    (wr && paddr == `RSC_OFF_CAUSE2 && pwdata[0] && vcc_ok) |=> st_ff.cws_flag)
    else $error("warm flag not set");
  chk_independent_watchdog_flag: assert property (@(posedge pclk) disable iff (!presetn)
    independent_watchdog_underflow |=> st_ff.independent_watchdog_flag) else $error("independent_watchdog flag missing");
  chk_pvd_flag: assert property (@(posedge pclk) disable iff (!presetn)
    mon_rst[1] |=> st_ff.pvd_flag[1]) else $error("monitor flag missing");
  chk_lvl_range: assert property (@(posedge pclk) disable iff (!presetn)
    st_ff.lvl1 <= 4'hc && st_ff.lvl2 <= 4'hc) else $error("level out of range");
  chk_sw_flag: assert property (@(posedge pclk) disable iff (!presetn)
    (st_ff.sw_req && st_ff.seq == reset_source_pkg::ST_RUN && pin_ok && vcc_ok)
    |=> st_ff.sw_flag && system_reset) else $error("software reset lost");
  chk_wake_set: assert property (@(posedge pclk) disable iff (!presetn)
    (deep_standby_cancel && st_ff.seq == reset_source_pkg::ST_RUN && pin_ok && vcc_ok)
    |=> (st_ff.wake & $past(deep_standby_wake_src)) == $past(deep_standby_wake_src))
    else $error("wake flag not recorded");
endmodule

// ==== tb/supply_pin_model.sv ====
// Far-side model: the external reset pin driver and the supply comparators.
// Assumes the bench sets the wanted levels; lines change only after a pclk edge.
module supply_pin_model (
  input wire logic pclk,
  input wire logic want_pin_n,
  input wire logic want_supply_ok,
  input wire logic [2:0] want_mon,
  input wire logic want_batt,
  output logic external_reset_pin_n,
  output logic supply_above_por,
  output logic [2:0] monitor_below,
  output logic battery_below_por
);
  timeunit 1ns;
  timeprecision 1ps;

  // ==========================================================
  // Comparator outputs
  // A real comparator answers a little late; one flop stands in for that delay.
  initial
  begin
    external_reset_pin_n = 1'b1;
    supply_above_por = 1'b0;
    monitor_below = 3'b000;
    battery_below_por = 1'b0;
  end

  always @(posedge pclk)
  begin
    external_reset_pin_n <= want_pin_n;
    supply_above_por <= want_supply_ok;
    monitor_below <= want_mon;
    battery_below_por <= want_batt;
  end
endmodule

// ==== tb/reset_source_controller_test.sv ====
// Self-checking bench for the reset source controller, driven over APB.
// Assumes the short hold parameters set below and the supply_pin_model partner.
module reset_source_controller_test;
  timeunit 1ns;
  timeprecision 1ps;

  // ==========================================================
  // Signals
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, system_reset, oscillator_start;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic pin_req, supply_req, batt_req, strap, cancel, watchdog_nmi;
  logic [2:0] mon_req, monitor_level_irq, monitor0_level_sel;
  logic [3:0] monitor1_level_sel, monitor2_level_sel;
  logic [7:0] wake_src;
  logic independent_watchdog_underflow, independent_watchdog_count_tick, independent_watchdog_reset_select;
  logic wdt_underflow, wdt_count_tick, wdt_reset_select;
  logic cpu_lockup, bus_error, mem_error;
  logic pin_n, supply_ok, batt_low;
  logic [2:0] mon_low;
  int err_total, checks, hi;

  supply_pin_model model_u (.pclk(pclk), .want_pin_n(pin_req), .want_supply_ok(supply_req),
    .want_mon(mon_req), .want_batt(batt_req), .external_reset_pin_n(pin_n),
    .supply_above_por(supply_ok), .monitor_below(mon_low), .battery_below_por(batt_low));

  reset_source_controller #(.POR_HOLD_CYC(20), .PVD_STAB_CYC(10), .DSBY_WAIT_CYC(10),
    .WAKE_W(8)) dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .external_reset_pin_n(pin_n), .supply_above_por(supply_ok),
    .monitor_below(mon_low), .battery_below_por(batt_low),
    .monitor0_after_reset_select(strap), .independent_watchdog_underflow(independent_watchdog_underflow),
    .independent_watchdog_count_tick(independent_watchdog_count_tick), .independent_watchdog_reset_select(independent_watchdog_reset_select),
    .wdt_underflow(wdt_underflow), .wdt_count_tick(wdt_count_tick),
    .wdt_reset_select(wdt_reset_select), .cpu_lockup(cpu_lockup), .bus_error(bus_error),
    .mem_error(mem_error), .deep_standby_cancel(cancel), .deep_standby_wake_src(wake_src),
    .system_reset(system_reset), .oscillator_start(oscillator_start),
    .monitor_level_irq(monitor_level_irq), .watchdog_nmi(watchdog_nmi),
    .monitor0_level_sel(monitor0_level_sel), .monitor1_level_sel(monitor1_level_sel),
    .monitor2_level_sel(monitor2_level_sel));

  // ==========================================================
  // Tasks
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp)
    begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do
      @(posedge pclk);
    while (pready !== 1'b1);
    rd = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rdchk(input logic [11:0] a, input logic [31:0] exp, input string nm);
    apb(1'b0, a, 32'h0);
    chk(nm, exp, rd);
  endtask

  // Waits a bounded span for the system reset to reach a level.
  task automatic wait_rst(input logic v, input int n);
    for (int i = 0; i < n && system_reset !== v; i++)
      @(posedge pclk);
    chk("system_reset", {31'h0, v}, {31'h0, system_reset});
  endtask

  task automatic wrap_up;
    $display("mismatches %0d comparisons %0d", err_total, checks);
    if (err_total == 0 && checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // ==========================================================
  // Clock and watchdog
  initial
  begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end

  initial
  begin
    repeat (5000) @(posedge pclk);
    err_total++;
    wrap_up();
  end

  // ==========================================================
  // Tests
  initial
  begin
    {presetn, psel, penable, pwrite, paddr, pwdata, supply_req, batt_req, cancel} = '0;
    {independent_watchdog_underflow, independent_watchdog_count_tick, independent_watchdog_reset_select, wake_src, mon_req} = '0;
    {wdt_underflow, wdt_count_tick, wdt_reset_select, cpu_lockup, bus_error, mem_error} = '0;
    {pin_req, strap} = 2'b11;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    repeat (30) @(posedge pclk);
    chk("system_reset", 1, system_reset);
    supply_req <= 1'b1;
    repeat (10) @(posedge pclk);
    chk("system_reset", 1, system_reset);
    wait_rst(1'b0, 60);
    rdchk(12'h000, 32'h1, "cause0");
    rdchk(12'h008, 32'h0, "cause2");
    apb(1'b0, 12'h00c, 32'h0);
    chk("monitor_enables", 0, rd & 32'h6);
    apb(1'b1, 12'h008, 32'h0);
    rdchk(12'h008, 32'h0, "cause2");
    apb(1'b1, 12'h008, 32'h1);
    rdchk(12'h008, 32'h1, "cause2");
    apb(1'b1, 12'h008, 32'h0);
    rdchk(12'h008, 32'h1, "cause2");
    // No watchdog is counting yet, so neither needs servicing first.
    apb(1'b1, 12'h018, 32'h4);
    wait_rst(1'b1, 6);
    wait_rst(1'b0, 40);
    rdchk(12'h004, 32'h4, "cause1");
    pin_req <= 1'b0;
    repeat (8) @(posedge pclk);
    repeat (8)
    begin
      @(posedge pclk);
      chk("system_reset", 1, system_reset);
    end
    pin_req <= 1'b1;
    wait_rst(1'b0, 80);
    rdchk(12'h000, 32'h0, "cause0");
    rdchk(12'h008, 32'h1, "cause2");
    for (int w = 0; w < 2; w++)
    begin
      @(posedge pclk);
      {wdt_underflow, independent_watchdog_underflow} <= 2'b01 << w;
      {wdt_reset_select, independent_watchdog_reset_select} <= 2'b00;
      #1 chk("watchdog_nmi", 1, watchdog_nmi);
      @(posedge pclk);
      {wdt_reset_select, independent_watchdog_reset_select} <= 2'b11;
      {wdt_count_tick, independent_watchdog_count_tick} <= 2'b01 << w;
      @(posedge pclk);
      {wdt_underflow, independent_watchdog_underflow, wdt_count_tick, independent_watchdog_count_tick} <= 4'h0;
      hi = 0;
      repeat (8)
      begin
        @(posedge pclk);
        hi += system_reset;
      end
      chk("reset_cycles", 1, 32'(hi));
    end
    mon_req <= 3'b001;
    wait_rst(1'b1, 20);
    repeat (20) @(posedge pclk);
    chk("system_reset", 1, system_reset);
    mon_req <= 3'b000;
    wait_rst(1'b0, 60);
    apb(1'b1, 12'h00c, 32'hc712);
    @(posedge pclk);
    chk("monitor0_level_sel", 7, monitor0_level_sel);
    chk("monitor1_level_sel", 12, monitor1_level_sel);
    apb(1'b1, 12'h00c, 32'h5d712);
    @(posedge pclk);
    chk("monitor1_level_sel", 12, monitor1_level_sel);
    chk("monitor2_level_sel", 5, monitor2_level_sel);
    mon_req <= 3'b010;
    repeat (8) @(posedge pclk);
    chk("monitor_level_irq", 2, monitor_level_irq);
    chk("system_reset", 0, system_reset);
    mon_req <= 3'b000;
    wake_src <= 8'h05;
    cancel <= 1'b1;
    @(posedge pclk);
    cancel <= 1'b0;
    wake_src <= 8'h00;
    wait_rst(1'b1, 10);
    chk("oscillator_start", 1, oscillator_start);
    wait_rst(1'b0, 60);
    rdchk(12'h014, 32'h5, "wake_flags");
    apb(1'b1, 12'h014, 32'h1);
    rdchk(12'h014, 32'h4, "wake_flags");
    for (int i = 0; i < 3; i++)
    begin
      {mem_error, bus_error, cpu_lockup} <= 3'b001 << i;
      @(posedge pclk);
      {mem_error, bus_error, cpu_lockup} <= 3'b000;
      wait_rst(1'b1, 10);
      wait_rst(1'b0, 80);
    end
    batt_req <= 1'b1;
    wait_rst(1'b1, 20);
    batt_req <= 1'b0;
    wait_rst(1'b0, 80);
    rdchk(12'h000, 32'h32, "cause0");
    rdchk(12'h004, 32'h3f, "cause1");
    rdchk(12'h008, 32'h1, "cause2");
    apb(1'b1, 12'h010, 32'h0);
    rdchk(12'h010, 32'h0, "wd_status");
    rdchk(12'h0fc, 32'h0, "unmapped");
    chk("pslverr", 0, {31'h0, pslverr});
    wrap_up();
  end
endmodule
